// >>> irq_prio_pkg.sv
// Package: register map, field layout and carriers of the priority/enable block
package irq_prio_pkg;

   // Register indices as printed; the APB byte address is four times the index
   localparam int             ADDR_W          = 18;
   localparam logic [15:0]    IDX_PRIO_A      = 16'hff20;
   localparam logic [15:0]    IDX_PRIO_B      = 16'hff21;
   localparam logic [15:0]    IDX_TIMER_EN    = 16'hff22;
   localparam logic [15:0]    IDX_PERIPH_EN   = 16'hff23;
   localparam logic [15:0]    IDX_IRQ_STATUS  = 16'hff28;
   localparam logic [15:0]    IDX_IRQ_MASK    = 16'hff29;
   localparam logic [15:0]    IDX_IRQ_STATE   = 16'hff2a;

   localparam logic [ADDR_W-1:0] ADDR_PRIO_A     = {IDX_PRIO_A, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PRIO_B     = {IDX_PRIO_B, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_TIMER_EN   = {IDX_TIMER_EN, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PERIPH_EN  = {IDX_PERIPH_EN, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATE  = {IDX_IRQ_STATE, 2'b00};

   // Widths
   localparam int             REG_W           = 8;
   localparam int             NUM_SRC         = 16;
   localparam int             LEVEL_W         = 2;

   // Reset values
   localparam logic [7:0]     RST_BYTE        = 8'h00;
   localparam logic [15:0]    RST_HALF        = 16'h0000;
   localparam logic [1:0]     LEVEL_ZERO      = 2'h0;

   // Implemented bits; the rest read zero and ignore writes
   localparam logic [7:0]     PRIO_A_BITS     = 8'hff;
   localparam logic [7:0]     PRIO_B_BITS     = 8'h0f;
   localparam logic [7:0]     TIMER_EN_BITS   = 8'h7f;
   localparam logic [7:0]     PERIPH_EN_BITS  = 8'hff;
   localparam logic [15:0]    SRC_BITS        = {PERIPH_EN_BITS, TIMER_EN_BITS};

   // Source bit positions: {periph_irq_enables, timer_irq_enables}
   localparam int             SRC_SERIAL_TX   = 8;
   localparam int             SRC_SERIAL_RX   = 9;
   localparam int             SRC_SERIAL_ERR  = 10;
   localparam int             SRC_KEY_LOWER   = 11;
   localparam int             SRC_KEY_UPPER   = 12;
   localparam int             SRC_KEYPAIR     = 13;
   localparam int             SRC_PROGT_A     = 14;
   localparam int             SRC_PROGT_B     = 15;

   // Group membership of source bits
   localparam logic [15:0]    GRP_KEYLOW8     = 16'h1800;
   localparam logic [15:0]    GRP_SERIAL      = 16'h0700;
   localparam logic [15:0]    GRP_STOPWATCH   = 16'h0070;
   localparam logic [15:0]    GRP_CLOCKTIMER  = 16'h000f;
   localparam logic [15:0]    GRP_PROGTIMER   = 16'hc000;
   localparam logic [15:0]    GRP_KEYPAIR     = 16'h2000;

   // First priority register, msb first as in the byte
   typedef struct packed {
      logic [1:0] keylow8;
      logic [1:0] serial;
      logic [1:0] stopwatch;
      logic [1:0] clocktimer;
   } prio_a_t;

   // Second priority register, low nibble
   typedef struct packed {
      logic [1:0] progtimer;
      logic [1:0] keypair;
   } prio_b_t;

   // Timer enables, bit 7 unused
   typedef struct packed {
      logic       unused;
      logic       sw_hundred_hz_en;
      logic       sw_ten_hz_en;
      logic       sw_one_hz_en;
      logic       ct_per_minute_en;
      logic       ct_eight_hz_en;
      logic       ct_two_hz_en;
      logic       ct_one_hz_en;
   } timer_en_t;

   typedef struct packed {
      logic       progtimer_b_en;
      logic       progtimer_a_en;
      logic       keypair_irq_en;
      logic       key_upper_nibble_en;
      logic       key_lower_nibble_en;
      logic       serial_error_en;
      logic       serial_receive_en;
      logic       serial_transmit_en;
   } periph_en_t;

endpackage

// >>> event_latch.sv
// Sticky event flags with write-one-to-clear, set wins over clear
`timescale 1ns/1ps
module event_latch
   import irq_prio_pkg::*;
#(
   parameter int          WIDTH = NUM_SRC
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic [WIDTH-1:0]  set_vec,
   input  wire logic [WIDTH-1:0]  clr_vec,
   output logic      [WIDTH-1:0]  flags
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         // An event in the clearing cycle is kept
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flags[i] <= 1'b0;
            end else if (ce) begin
               if (set_vec[i]) begin
                  flags[i] <= 1'b1;
               end else if (clr_vec[i]) begin
                  flags[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

endmodule

// >>> irq_prio_regs.sv
// Interrupt priority and enable registers with APB access and pending logic
//
// Behaviour
// - Two-bit R/W priority for eight-line key group, value equals level.
// - Two-bit R/W priority for serial interface group, levels 0 to 3.
// - Two-bit R/W priority for stopwatch timer group, levels 0 to 3.
// - Clock timer priority sits in bits 1:0 of the first register.
// - Programmable timer priority sits in bits 3:2 of second register.
// - Two-line key priority sits in bits 1:0 of second register.
// - Stopwatch 100 Hz, 10 Hz, 1 Hz enable bits; one enables.
// - Clock timer minute, 8 Hz, 2 Hz, 1 Hz enables in bits 3:0.
// - Programmable timer 1 and 0 enables in bits 7:6 of second enables.
// - Separate enables for key pair, upper and lower key nibbles.
// - Serial error, receive bit 1 and transmit bit 0 enables.
`timescale 1ns/1ps
module irq_prio_regs
   import irq_prio_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [NUM_SRC-1:0]  src_event,
   output prio_a_t                  prio_a,
   output prio_b_t                  prio_b,
   output timer_en_t                timer_en,
   output periph_en_t               periph_en,
   output logic      [LEVEL_W-1:0]  irq_level,
   output logic                     irq
);

   logic [NUM_SRC-1:0]  irq_status;
   logic [NUM_SRC-1:0]  irq_mask;
   logic [NUM_SRC-1:0]  status_set;
   logic [NUM_SRC-1:0]  status_clr;
   logic [NUM_SRC-1:0]  enables;
   logic [NUM_SRC-1:0]  pending;
   logic                setup;
   logic                wr_access;
   logic                lane0;
   logic                lane1;
   logic                hit;
   logic [31:0]         next_rdata;
   logic [LEVEL_W-1:0]  next_level;

   // APB phases; ready is registered from setup, so read data comes from a flop with no wait state
   assign setup     = psel & ~penable;
   assign wr_access = psel & penable & pready & pwrite;
   assign lane0     = pstrb[0];
   assign lane1     = pstrb[1];

   assign enables   = {periph_en, timer_en} & SRC_BITS;
   assign pending   = irq_status & irq_mask;

   // Address decode and read mux, sampled in the setup cycle
   always_comb begin
      hit        = 1'b1;
      next_rdata = 32'h0000_0000;
      case (paddr)
         ADDR_PRIO_A: begin
            next_rdata[REG_W-1:0] = prio_a & PRIO_A_BITS;
         end
         ADDR_PRIO_B: begin
            // Upper nibble has no storage
            next_rdata[REG_W-1:0] = {4'h0, prio_b} & PRIO_B_BITS;
         end
         ADDR_TIMER_EN: begin
            next_rdata[REG_W-1:0] = timer_en & TIMER_EN_BITS;
         end
         ADDR_PERIPH_EN: begin
            next_rdata[REG_W-1:0] = periph_en & PERIPH_EN_BITS;
         end
         ADDR_IRQ_STATUS: begin
            next_rdata[NUM_SRC-1:0] = irq_status;
         end
         ADDR_IRQ_MASK: begin
            next_rdata[NUM_SRC-1:0] = irq_mask;
         end
         ADDR_IRQ_STATE: begin
            next_rdata[LEVEL_W:0] = {irq, irq_level};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Bus answer: pready one cycle after setup, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready <= setup;
         if (setup) begin
            pslverr <= ~hit;
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
         end
      end
   end

   // Priority register A fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_a <= prio_a_t'(RST_BYTE);
      end else if (ce) begin
         if (wr_access && lane0 && paddr == ADDR_PRIO_A) begin
            prio_a.keylow8    <= pwdata[7:6];
            prio_a.serial     <= pwdata[5:4];
            prio_a.stopwatch  <= pwdata[3:2];
            prio_a.clocktimer <= pwdata[1:0];
         end
      end
   end

   // Priority register B fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_b <= prio_b_t'(RST_BYTE[3:0]);
      end else if (ce) begin
         if (wr_access && lane0 && paddr == ADDR_PRIO_B) begin
            prio_b.progtimer <= pwdata[3:2];
            prio_b.keypair   <= pwdata[1:0];
         end
      end
   end

   // Timer interrupt enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_en <= timer_en_t'(RST_BYTE);
      end else if (ce) begin
         if (wr_access && lane0 && paddr == ADDR_TIMER_EN) begin
            timer_en.unused           <= 1'b0;
            timer_en.sw_hundred_hz_en <= pwdata[6];
            timer_en.sw_ten_hz_en     <= pwdata[5];
            timer_en.sw_one_hz_en     <= pwdata[4];
            timer_en.ct_per_minute_en <= pwdata[3];
            timer_en.ct_eight_hz_en   <= pwdata[2];
            timer_en.ct_two_hz_en     <= pwdata[1];
            timer_en.ct_one_hz_en     <= pwdata[0];
         end
      end
   end

   // Peripheral interrupt enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_en <= periph_en_t'(RST_BYTE);
      end else if (ce) begin
         if (wr_access && lane0 && paddr == ADDR_PERIPH_EN) begin
            periph_en.progtimer_b_en      <= pwdata[7];
            periph_en.progtimer_a_en      <= pwdata[6];
            periph_en.keypair_irq_en      <= pwdata[5];
            periph_en.key_upper_nibble_en <= pwdata[4];
            periph_en.key_lower_nibble_en <= pwdata[3];
            periph_en.serial_error_en     <= pwdata[2];
            periph_en.serial_receive_en   <= pwdata[1];
            periph_en.serial_transmit_en  <= pwdata[0];
         end
      end
   end

   // Mask register, both byte lanes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= RST_HALF;
      end else if (ce) begin
         if (wr_access && paddr == ADDR_IRQ_MASK) begin
            if (lane0) begin
               irq_mask[7:0] <= pwdata[7:0] & SRC_BITS[7:0];
            end
            if (lane1) begin
               irq_mask[15:8] <= pwdata[15:8] & SRC_BITS[15:8];
            end
         end
      end
   end

   // Sources are only latched while enabled, so a disabled source is silent
   assign status_set = src_event & enables;

   always_comb begin
      status_clr = '0;
      if (wr_access && paddr == ADDR_IRQ_STATUS) begin
         status_clr = pwdata[NUM_SRC-1:0] & {{8{lane1}}, {8{lane0}}};
      end
   end

   event_latch #(
      .WIDTH   (NUM_SRC)
   ) u_event_latch (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .set_vec (status_set),
      .clr_vec (status_clr),
      .flags   (irq_status)
   );

   function automatic logic [LEVEL_W-1:0] raise(
      input logic [LEVEL_W-1:0] cur,
      input logic [NUM_SRC-1:0] pend,
      input logic [NUM_SRC-1:0] grp,
      input logic [LEVEL_W-1:0] lvl
   );
      raise = ((|(pend & grp)) && lvl > cur) ? lvl : cur;
   endfunction

   // Highest programmed level among pending groups
   always_comb begin
      next_level = LEVEL_ZERO;
      next_level = raise(next_level, pending, GRP_KEYLOW8, prio_a.keylow8);
      next_level = raise(next_level, pending, GRP_SERIAL, prio_a.serial);
      next_level = raise(next_level, pending, GRP_STOPWATCH,
                         prio_a.stopwatch);
      next_level = raise(next_level, pending, GRP_CLOCKTIMER,
                         prio_a.clocktimer);
      next_level = raise(next_level, pending, GRP_PROGTIMER,
                         prio_b.progtimer);
      next_level = raise(next_level, pending, GRP_KEYPAIR, prio_b.keypair);
   end

   // Registered outputs lag the status by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq       <= 1'b0;
         irq_level <= LEVEL_ZERO;
      end else if (ce) begin
         irq       <= |pending;
         irq_level <= next_level;
      end
   end

endmodule

// >>> irq_prio_regs_sva.sv
// Assertions on the ports of the priority and enable register block
`timescale 1ns/1ps
module irq_prio_regs_sva
   import irq_prio_pkg::*;
(
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               ce,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [ADDR_W-1:0]  paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire prio_a_t            prio_a,
   input wire prio_b_t            prio_b,
   input wire timer_en_t          timer_en,
   input wire periph_en_t         periph_en,
   input wire logic [LEVEL_W-1:0] irq_level,
   input wire logic               irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      ce && psel && !penable;
   endsequence

   sequence s_wr(logic [ADDR_W-1:0] a);
      ce && psel && penable && pready && pwrite && pstrb[0] && paddr == a;
   endsequence

   a_setup_then_ready:
   assert property (s_setup |=> pready) else $error("no ready after setup");
   a_prio_a_write:
   assert property (s_wr(ADDR_PRIO_A) |=> prio_a == $past(pwdata[7:0]))
      else $error("first priority register not written");
   a_prio_b_write:
   assert property (s_wr(ADDR_PRIO_B) |=> prio_b == $past(pwdata[3:0]))
      else $error("second priority register not written");
   a_timer_en_write:
   assert property (s_wr(ADDR_TIMER_EN) |=>
      timer_en == {1'b0, $past(pwdata[6:0])})
      else $error("timer enables not written");
   a_periph_en_write:
   assert property (s_wr(ADDR_PERIPH_EN) |=>
      periph_en == $past(pwdata[7:0])) else $error("periph enables wrong");
   a_reset_all_zero:
   assert property ($rose(presetn) |-> prio_a == 8'h00 && prio_b == 4'h0
      && timer_en == 8'h00 && periph_en == 8'h00)
      else $error("fields not zero after reset");
   a_regs_hold_idle:
   assert property (!(psel && penable && pwrite) |=> $stable(prio_a)
      && $stable(prio_b) && $stable(periph_en))
      else $error("register changed without write");
   a_refused_read_zero:
   assert property (pslverr |-> prdata == 32'h0)
      else $error("error answer carries data");
   a_idle_level_zero:
   assert property (!irq |-> irq_level == 2'h0)
      else $error("level shown without interrupt");
endmodule

bind irq_prio_regs irq_prio_regs_sva u_sva (.pclk, .presetn, .ce, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .prio_a, .prio_b, .timer_en, .periph_en, .irq_level, .irq);

// >>> event_source.sv
// Model of the interrupt sources: one-cycle event pulses on request
`timescale 1ns/1ps
module event_source
   import irq_prio_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic [NUM_SRC-1:0] fire,
   output logic      [NUM_SRC-1:0] src_event
);
   // Registered so that pulses never change on the sampling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_event <= 16'h0000;
      end else begin
         src_event <= fire;
      end
   end
endmodule

// >>> test_interrupt_priority_enable_regs.sv
// Testbench of the priority and enable registers with an APB master
`timescale 1ns/1ps
module test_interrupt_priority_enable_regs
   import irq_prio_pkg::*;
;
   logic               pclk, presetn, ce, psel, penable, pwrite;
   logic               pready, pslverr, irq, err;
   logic [ADDR_W-1:0]  paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic [3:0]         pstrb;
   logic [NUM_SRC-1:0] src_event, fire;
   logic [LEVEL_W-1:0] irq_level;
   prio_a_t            prio_a;
   prio_b_t            prio_b;
   timer_en_t          timer_en;
   periph_en_t         periph_en;
   int                 bad_count, check_count;

   irq_prio_regs u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .src_event,
      .prio_a, .prio_b, .timer_en, .periph_en, .irq_level, .irq);
   event_source u_src (.pclk, .presetn, .fire, .src_event);

   always #12.5 pclk = ~pclk;

   task automatic final_report();
      if (bad_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until ready is sampled high
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: no ready", $time);
         final_report();
      end
   endtask

   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, {IDX_PRIO_A + 16'(i), 2'b00}, 32'h0);
         chk(rd, 32'h0);
      end
   endtask

   task automatic t_prio();
      bus(1'b1, ADDR_PRIO_A, 32'hffffff1b);
      // Fields settle at the access edge; look half a cycle later
      @(negedge pclk);
      chk({30'h0, prio_a.keylow8}, 32'h0);
      chk({30'h0, prio_a.serial}, 32'h1);
      chk({30'h0, prio_a.stopwatch}, 32'h2);
      chk({30'h0, prio_a.clocktimer}, 32'h3);
      for (int lv = 0; lv < 4; lv++) begin
         bus(1'b1, ADDR_PRIO_A, {24'hffffff, {4{2'(lv)}}});
         bus(1'b0, ADDR_PRIO_A, 32'h0);
         chk(rd, {24'h0, {4{2'(lv)}}});
         bus(1'b1, ADDR_PRIO_B, {24'hffffff, {4{2'(lv)}}});
         bus(1'b0, ADDR_PRIO_B, 32'h0);
         chk(rd, {28'h0, {2{2'(lv)}}});
         chk({28'h0, prio_b}, {28'h0, {2{2'(lv)}}});
      end
   endtask

   task automatic t_enables();
      for (int b = 0; b < 8; b++) begin
         bus(1'b1, ADDR_TIMER_EN, 32'h1 << b);
         bus(1'b0, ADDR_TIMER_EN, 32'h0);
         chk(rd, (b == 7) ? 32'h0 : 32'h1 << b);
         bus(1'b1, ADDR_PERIPH_EN, 32'h1 << b);
         bus(1'b0, ADDR_PERIPH_EN, 32'h0);
         chk(rd, 32'h1 << b);
         chk({24'h0, periph_en}, 32'h1 << b);
         chk({24'h0, timer_en}, 32'(8'h7f & 8'(1 << b)));
      end
   endtask

   task automatic t_unmapped();
      bus(1'b1, {16'hff24, 2'b00}, 32'hff);
      chk({31'h0, err}, 32'h1);
      bus(1'b0, {16'hff24, 2'b00}, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Without byte lane 0 an 8-bit register keeps its value
      pstrb <= 4'he;
      bus(1'b1, ADDR_PRIO_B, 32'h0);
      pstrb <= 4'hf;
      bus(1'b0, ADDR_PRIO_B, 32'h0);
      chk(rd, 32'hf);
   endtask

   // Fixed waits follow the one-edge lags given for status and irq
   task automatic pulse(input logic [NUM_SRC-1:0] v);
      @(posedge pclk);
      fire <= v;
      @(posedge pclk);
      fire <= 16'h0000;
      repeat (4) @(posedge pclk);
   endtask

   task automatic t_irq();
      bus(1'b1, ADDR_PRIO_A, 32'h3);
      bus(1'b1, ADDR_TIMER_EN, 32'h1);
      bus(1'b1, ADDR_IRQ_MASK, 32'h1);
      pulse(16'h0001);
      chk({31'h0, irq}, 32'h1);
      chk({30'h0, irq_level}, 32'h3);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk(rd, 32'h1);
      bus(1'b0, ADDR_IRQ_STATE, 32'h0);
      chk(rd, 32'h7);
      bus(1'b1, ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, ADDR_IRQ_STATUS, 32'hffff);
      bus(1'b1, ADDR_TIMER_EN, 32'h0);
      pulse(16'h0001);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk(rd, 32'h0);
      // A low clock enable freezes the flags, so this event is lost
      bus(1'b1, ADDR_TIMER_EN, 32'h1);
      ce <= 1'b0;
      pulse(16'h0001);
      ce <= 1'b1;
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk(rd, 32'h0);
   endtask

   initial begin
      pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0;
      penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = 32'h0;
      pstrb = 4'hf; fire = 16'h0000; rd = 32'h0; err = 1'b0;
      bad_count = 0; check_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_prio();
      t_enables();
      t_unmapped();
      t_irq();
      final_report();
   end
endmodule
